// ===== adpcm_channel_config_port.sv
// Notes on behaviour
// - Idle bit disables side, tri-states its output.
// - Both channels idle gives low-power standby.
// - Coefficient reset bit self-clears when reset completes.
// - Reset pin pulse resets the algorithm.
// - Command address must match six address pins.
// - Foreign clocks cross into core domain safely.
// - Input sampled on bit clock fall, slot only.
// - Output data moves on each bit clock rise; driven in slot only.
// - Config bits taken on serial rise, LSB first.
// - Writes accepted only while chip select low.
// - Strap high enables port; low selects hardware mode.
// - Pass-through needs bypass set and idle clear.
// - Pass-through width: eight bits encoding, else four.
// - Format bit picks A-law or mu-law per side.
// - Direction bit picks encode or decode otherwise.
// - Command bit six picks channel X or Y.
// - Algorithm bits decode to 32, 24, 16 kbps.
// - Address mismatch ignores rest of the write.
// - Writes are two or four bytes long.
// - Reset clears control bits, sets idle bits.
// - Data outputs tri-state during register update.
`timescale 1ns/100ps
`default_nettype none
module adpcm_channel_config_port import adpcm_cfg_pkg::*; (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_port_select_strap,
  input wire logic [5:0] i_device_addr_pins,
  input wire logic i_serial_clock,
  input wire logic i_config_serial_in,
  input wire logic i_chip_select_n,
  input wire logic i_side_x_bit_clock,
  input wire logic i_side_x_frame_sync,
  input wire logic i_side_x_data_in,
  input wire logic i_side_y_bit_clock,
  input wire logic i_side_y_frame_sync,
  input wire logic i_side_y_data_in,
  output var logic o_side_x_data_out,
  output var logic o_side_x_data_out_oe,
  output var logic o_side_y_data_out,
  output var logic o_side_y_data_out_oe,
  output var logic [7:0] o_x_control,
  output var logic [7:0] o_y_control,
  output var chan_mode_type o_x_mode,
  output var chan_mode_type o_y_mode,
  output var rate_type o_x_rate,
  output var rate_type o_y_rate,
  output var logic o_x_mu_law,
  output var logic o_y_mu_law,
  output var logic o_standby,
  output var logic o_update_busy
);
  // Upper bound used by the self-clear check below.
  localparam int A_CLR_MAX = COEFF_RST_CYCLES + 2;

  // Serial pins and straps, two stages each: {cs_n, data, clock}.
  logic [2:0] sp_sync1_r;
  logic [2:0] sp_sync2_r;
  logic [6:0] strap_sync1_r;
  logic [6:0] strap_sync2_r;
  // Previous synced serial clock for edge detection.
  logic sclk_d_r;
  logic sclk_rise;
  logic port_active;
  logic [5:0] addr_s;
  // Receive state of the serial port.
  sp_state_type st_r;
  sp_state_type st_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [7:0] cfg_shift_r;
  logic [7:0] cfg_shift_nxt;
  // Channel that the current write addresses.
  logic side_r;
  logic side_nxt;
  logic busy_nxt;
  // One-cycle load strobes for control and slot bytes.
  logic [2:0] ld_r;
  logic [2:0] ld_nxt;
  // Per-channel register state, indexed by CH_X and CH_Y.
  logic [7:0] ctrl_r [2];
  logic [7:0] ctrl_nxt [2];
  logic [7:0] rst_cnt_r [2];
  logic [7:0] rst_cnt_nxt [2];
  logic [5:0] islot_r [2];
  logic [5:0] islot_nxt [2];
  logic [5:0] oslot_r [2];
  logic [5:0] oslot_nxt [2];
  chan_mode_type mode_r [2];
  chan_mode_type mode_nxt [2];
  rate_type rate_r [2];
  rate_type rate_nxt [2];
  logic law_r [2];
  logic law_nxt [2];
  logic standby_nxt;
  // Pin-side wiring for the two PCM ports.
  logic [1:0] bclk_w;
  logic [1:0] fsync_w;
  logic [1:0] din_w;
  logic [1:0] dout_w;
  logic [1:0] doe_w;

  assign addr_s = strap_sync2_r[5:0];
  assign sclk_rise = sp_sync2_r[0] & ~sclk_d_r;
  // The port listens only in software mode with chip select low.
  assign port_active = strap_sync2_r[6] & ~sp_sync2_r[2];

  // Serial receiver: bytes assemble LSB first on clock rises.
  always_comb begin
    st_nxt = st_r;
    bit_cnt_nxt = bit_cnt_r;
    cfg_shift_nxt = cfg_shift_r;
    side_nxt = side_r;
    busy_nxt = o_update_busy;
    ld_nxt = 3'h0;
    if (!port_active) begin
      // Chip select high ends any write, whatever its length.
      st_nxt = SP_CMD;
      bit_cnt_nxt = 3'h0;
      busy_nxt = 1'b0;
    end else if (sclk_rise) begin
      cfg_shift_nxt = {sp_sync2_r[1], cfg_shift_r[7:1]};
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        case (st_r)
          SP_CMD: begin
            // The reserved top bit is not checked.
            if (cfg_shift_nxt[CMD_ADDR_MSB:0] == addr_s) begin
              st_nxt = SP_CTRL;
              side_nxt = cfg_shift_nxt[CMD_SIDE];
              busy_nxt = 1'b1;
            end else begin
              st_nxt = SP_SKIP;
            end
          end
          SP_CTRL: begin
            // Only a whole byte reaches the channel register.
            ld_nxt[LD_CTRL] = 1'b1;
            st_nxt = SP_ISLOT;
          end
          SP_ISLOT: begin
            ld_nxt[LD_ISLOT] = 1'b1;
            st_nxt = SP_OSLOT;
          end
          SP_OSLOT: begin
            ld_nxt[LD_OSLOT] = 1'b1;
            st_nxt = SP_SKIP;
          end
          SP_SKIP: begin
            st_nxt = SP_SKIP;
          end
          default: begin
            st_nxt = SP_SKIP;
          end
        endcase
      end
    end
  end

  // Registers of the serial receiver and its synchronisers.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // Idle levels of the pins: deselected, data low, clock low.
      // A high clock here would look like a rise right after reset.
      sp_sync1_r <= 3'h4;
      sp_sync2_r <= 3'h4;
      strap_sync1_r <= 7'h00;
      strap_sync2_r <= 7'h00;
      sclk_d_r <= 1'b0;
      st_r <= SP_CMD;
      bit_cnt_r <= 3'h0;
      cfg_shift_r <= 8'h00;
      side_r <= 1'b0;
      o_update_busy <= 1'b0;
      ld_r <= 3'h0;
    end else begin
      // The serial clock is foreign, so everything crosses twice.
      sp_sync1_r <= {i_chip_select_n, i_config_serial_in,
                     i_serial_clock};
      sp_sync2_r <= sp_sync1_r;
      strap_sync1_r <= {i_port_select_strap, i_device_addr_pins};
      strap_sync2_r <= strap_sync1_r;
      sclk_d_r <= sp_sync2_r[0];
      st_r <= st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      cfg_shift_r <= cfg_shift_nxt;
      side_r <= side_nxt;
      o_update_busy <= busy_nxt;
      ld_r <= ld_nxt;
    end
  end

  // Standby follows both idle bits; a slower host is assumed there.
  assign standby_nxt = ctrl_r[CH_X][CTL_IDLE] &
                       ctrl_r[CH_Y][CTL_IDLE];
  assign bclk_w = {i_side_x_bit_clock, i_side_y_bit_clock};
  assign fsync_w = {i_side_x_frame_sync, i_side_y_frame_sync};
  assign din_w = {i_side_x_data_in, i_side_y_data_in};

  // One register set and one PCM port per channel.
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    pcm_cfg_if cfg ();

    // Next values of the channel registers.
    always_comb begin
      ctrl_nxt[ch] = ctrl_r[ch];
      rst_cnt_nxt[ch] = rst_cnt_r[ch];
      islot_nxt[ch] = islot_r[ch];
      oslot_nxt[ch] = oslot_r[ch];
      if (ld_r[LD_CTRL] && side_r == 1'(ch)) begin
        // A fresh write wins over the self-clear in the same cycle.
        ctrl_nxt[ch] = cfg_shift_r;
        rst_cnt_nxt[ch] = cfg_shift_r[CTL_COEFF_RST] ?
                          8'(COEFF_RST_CYCLES) : 8'h00;
      end else if (ctrl_r[ch][CTL_COEFF_RST]) begin
        if (rst_cnt_r[ch] <= 8'h01) begin
          ctrl_nxt[ch][CTL_COEFF_RST] = 1'b0;
          rst_cnt_nxt[ch] = 8'h00;
        end else begin
          rst_cnt_nxt[ch] = rst_cnt_r[ch] - 8'h01;
        end
      end
      // Reserved top bits of the slot bytes are dropped.
      if (ld_r[LD_ISLOT] && side_r == 1'(ch)) begin
        islot_nxt[ch] = cfg_shift_r[SLOT_MSB:0];
      end
      if (ld_r[LD_OSLOT] && side_r == 1'(ch)) begin
        oslot_nxt[ch] = cfg_shift_r[SLOT_MSB:0];
      end
      // Idle beats bypass; bypass beats the coding direction.
      if (ctrl_r[ch][CTL_IDLE]) begin
        mode_nxt[ch] = MODE_IDLE;
      end else if (ctrl_r[ch][CTL_PASS]) begin
        mode_nxt[ch] = MODE_PASS;
      end else if (ctrl_r[ch][CTL_DIR]) begin
        mode_nxt[ch] = MODE_ENCODE;
      end else begin
        mode_nxt[ch] = MODE_DECODE;
      end
      rate_nxt[ch] = decode_algo(ctrl_r[ch]);
      law_nxt[ch] = ctrl_r[ch][CTL_MU_LAW];
    end

    // Channel registers; the reset pin restarts the algorithm.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        ctrl_r[ch] <= CTL_RESET;
        rst_cnt_r[ch] <= 8'h00;
        islot_r[ch] <= 6'h00;
        oslot_r[ch] <= 6'h00;
        mode_r[ch] <= MODE_IDLE;
        rate_r[ch] <= RATE_32K;
        law_r[ch] <= 1'b0;
      end else begin
        ctrl_r[ch] <= ctrl_nxt[ch];
        rst_cnt_r[ch] <= rst_cnt_nxt[ch];
        islot_r[ch] <= islot_nxt[ch];
        oslot_r[ch] <= oslot_nxt[ch];
        mode_r[ch] <= mode_nxt[ch];
        rate_r[ch] <= rate_nxt[ch];
        law_r[ch] <= law_nxt[ch];
      end
    end

    // A side drives only when active and no update is running.
    assign cfg.enable = ~ctrl_r[ch][CTL_IDLE] &
                        ~o_update_busy;
    assign cfg.bypass = ctrl_r[ch][CTL_PASS] &
                        ~ctrl_r[ch][CTL_IDLE];
    assign cfg.dir = ctrl_r[ch][CTL_DIR];
    assign cfg.in_slot = islot_r[ch];
    assign cfg.out_slot = oslot_r[ch];

    pcm_side_port u_port (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .cfg(cfg.port),
      .i_bit_clock(bclk_w[ch]),
      .i_frame_sync(fsync_w[ch]),
      .i_data_in(din_w[ch]),
      .o_data_out(dout_w[ch]),
      .o_data_oe(doe_w[ch])
    );
  end

  // Standby flag register.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_standby <= 1'b1;
    end else begin
      o_standby <= standby_nxt;
    end
  end

  // Outputs are taken straight from the flops above.
  assign o_side_x_data_out = dout_w[CH_X];
  assign o_side_x_data_out_oe = doe_w[CH_X];
  assign o_side_y_data_out = dout_w[CH_Y];
  assign o_side_y_data_out_oe = doe_w[CH_Y];
  assign o_x_control = ctrl_r[CH_X];
  assign o_y_control = ctrl_r[CH_Y];
  assign o_x_mode = mode_r[CH_X];
  assign o_y_mode = mode_r[CH_Y];
  assign o_x_rate = rate_r[CH_X];
  assign o_y_rate = rate_r[CH_Y];
  assign o_x_mu_law = law_r[CH_X];
  assign o_y_mu_law = law_r[CH_Y];

  // Last bit of a command byte arriving while the port listens.
  sequence s_cmd_byte_done;
    port_active && sclk_rise && bit_cnt_r == 3'h7 && st_r == SP_CMD;
  endsequence

  a_addr_match: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_cmd_byte_done ##0 (cfg_shift_r[6:1] == addr_s) |=>
      (o_update_busy && st_r == SP_CTRL))
    else $error("matching command byte not accepted");
  a_addr_mismatch: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_cmd_byte_done ##0 (cfg_shift_r[6:1] != addr_s) |=>
      (st_r == SP_SKIP && !o_update_busy))
    else $error("mismatching command byte not ignored");
  a_reset_values: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(i_arst_n) |-> (o_x_control == CTL_RESET &&
      o_y_control == CTL_RESET))
    else $error("control registers wrong after reset");
  a_standby_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ctrl_r[CH_X][CTL_IDLE] && ctrl_r[CH_Y][CTL_IDLE]) [*2] |-> o_standby)
    else $error("standby missing with both channels idle");
  a_coeff_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_x_control[CTL_COEFF_RST]) |->
      ##[1:A_CLR_MAX] !o_x_control[CTL_COEFF_RST])
    else $error("coefficient reset bit did not self-clear");
  a_busy_tristate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_update_busy |=> (!o_side_x_data_out_oe && !o_side_y_data_out_oe))
    else $error("data output driven during an update");
  a_strap_low: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !strap_sync2_r[6] |=> (!o_update_busy && ld_r == 3'h0))
    else $error("serial port active in hardware mode");
  a_whole_byte: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ((o_y_control & 8'hEF) != ($past(o_y_control) & 8'hEF)) |->
      $past(ld_r[LD_CTRL] && !side_r))
    else $error("control changed without a full byte load");
  a_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_x_control[CTL_IDLE] |=> !o_side_x_data_out_oe)
    else $error("idle side still drives its output");
endmodule
`default_nettype wire

// ===== adpcm_cfg_pkg.sv
`default_nettype none
package adpcm_cfg_pkg;
  // Core clock period; every timing count below derives from it.
  localparam int CLK_PERIOD_NS = 10;
  // Bit positions inside the channel_control byte.
  localparam int CTL_ALGO0 = 7;
  localparam int CTL_ALGO1 = 6;
  localparam int CTL_IDLE = 5;
  localparam int CTL_COEFF_RST = 4;
  localparam int CTL_PASS = 3;
  localparam int CTL_MU_LAW = 2;
  localparam int CTL_ALGO2 = 1;
  localparam int CTL_DIR = 0;
  // Bit positions inside the address_command_byte.
  localparam int CMD_SIDE = 6;
  localparam int CMD_ADDR_MSB = 5;
  // Time slot bytes carry a six bit slot number.
  localparam int SLOT_MSB = 5;
  // Channel indices, matching the side bit of the command byte.
  localparam int CH_Y = 0;
  localparam int CH_X = 1;
  // Indices of the load strobes raised by the serial port.
  localparam int LD_CTRL = 0;
  localparam int LD_ISLOT = 1;
  localparam int LD_OSLOT = 2;
  // Reset value of channel_control: only idle_power_down is set.
  localparam logic [7:0] CTL_RESET = 8'h20;
  // Time the coefficient reset takes before the bit self-clears.
  localparam int COEFF_RST_NS = 2000;
  localparam int COEFF_RST_CYCLES =
    (COEFF_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Serial port receive states, one-hot.
  typedef enum logic [4:0] {
    SP_CMD = 5'h01,
    SP_CTRL = 5'h02,
    SP_ISLOT = 5'h04,
    SP_OSLOT = 5'h08,
    SP_SKIP = 5'h10
  } sp_state_type;
  // Compression rate chosen by the three algorithm select bits.
  typedef enum logic [1:0] {
    RATE_32K = 2'h0,
    RATE_24K = 2'h1,
    RATE_16K = 2'h2,
    RATE_RSVD = 2'h3
  } rate_type;
  // Effective operating mode of one channel.
  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_PASS = 2'h1,
    MODE_ENCODE = 2'h2,
    MODE_DECODE = 2'h3
  } chan_mode_type;
  // Decodes the scattered algorithm select bits of a control byte.
  function automatic rate_type decode_algo(input logic [7:0] ctl);
    logic [2:0] sel;
    sel = {ctl[CTL_ALGO2], ctl[CTL_ALGO1], ctl[CTL_ALGO0]};
    case (sel)
      3'h0: decode_algo = RATE_32K;
      3'h7: decode_algo = RATE_24K;
      3'h5: decode_algo = RATE_16K;
      default: decode_algo = RATE_RSVD;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== pcm_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
// Per-side settings handed from the register bank to a PCM port.
interface pcm_cfg_if;
  logic enable;
  logic bypass;
  logic dir;
  logic [5:0] in_slot;
  logic [5:0] out_slot;
  modport ctl (output enable, output bypass, output dir,
               output in_slot, output out_slot);
  modport port (input enable, input bypass, input dir,
                input in_slot, input out_slot);
endinterface
`default_nettype wire

// ===== pcm_side_port.sv
`timescale 1ns/100ps
`default_nettype none
// One PCM/ADPCM time slot port, timed by edges of its own bit clock.
module pcm_side_port import adpcm_cfg_pkg::*; (
  input wire logic i_clk,
  input wire logic i_arst_n,
  pcm_cfg_if.port cfg,
  input wire logic i_bit_clock,
  input wire logic i_frame_sync,
  input wire logic i_data_in,
  output var logic o_data_out,
  output var logic o_data_oe
);
  // Synchroniser stages for {data, frame sync, bit clock}.
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  // Previous synced bit clock, for edge detection.
  logic bclk_d_r;
  logic bclk_rise;
  logic bclk_fall;
  // Bit position since the last frame sync.
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  // Incoming slot bits and the last complete slot.
  logic [7:0] in_shift_r;
  logic [7:0] in_shift_nxt;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  logic out_nxt;
  logic oe_nxt;
  logic in_w8;
  logic out_w8;
  logic [2:0] out_pos;

  // Slot number of a bit position for 8 or 4 bit slots.
  function automatic logic [5:0] slot_of(input logic [8:0] c,
                                         input logic w8);
    slot_of = w8 ? c[8:3] : c[7:2];
  endfunction

  // Bit position inside its slot.
  function automatic logic [2:0] pos_of(input logic [8:0] c,
                                        input logic w8);
    pos_of = w8 ? c[2:0] : {1'b0, c[1:0]};
  endfunction

  assign bclk_rise = sync2_r[0] & ~bclk_d_r;
  assign bclk_fall = ~sync2_r[0] & bclk_d_r;
  // Pass-through keeps one width both ways; coding swaps them.
  assign in_w8 = cfg.dir;
  assign out_w8 = cfg.bypass ? cfg.dir : ~cfg.dir;

  // Slot timing; output data only moves on a bit clock rise.
  always_comb begin
    out_pos = 3'h0;
    cnt_nxt = cnt_r;
    in_shift_nxt = in_shift_r;
    hold_nxt = hold_r;
    out_nxt = o_data_out;
    // Losing enable tri-states at once, not at the next slot.
    oe_nxt = o_data_oe & cfg.enable;
    if (bclk_fall && slot_of(cnt_r, in_w8) == cfg.in_slot) begin
      in_shift_nxt = {in_shift_r[6:0], sync2_r[2]};
      if (pos_of(cnt_r, in_w8) == (in_w8 ? 3'h7 : 3'h3)) begin
        hold_nxt = in_w8 ? in_shift_nxt : {4'h0, in_shift_nxt[3:0]};
      end
    end
    if (bclk_rise) begin
      cnt_nxt = sync2_r[1] ? 9'h000 : cnt_r + 9'h001;
      out_pos = pos_of(cnt_nxt, out_w8);
      oe_nxt = cfg.enable &&
               slot_of(cnt_nxt, out_w8) == cfg.out_slot;
      // Coded data comes from the engine; only pass-through is here.
      out_nxt = cfg.bypass &
                hold_r[out_w8 ? 3'h7 - out_pos : 3'h3 - out_pos];
    end
  end

  // Registers only; the pins are sampled twice before any use.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      bclk_d_r <= 1'b0;
      cnt_r <= 9'h000;
      in_shift_r <= 8'h00;
      hold_r <= 8'h00;
      o_data_out <= 1'b0;
      o_data_oe <= 1'b0;
    end else begin
      sync1_r <= {i_data_in, i_frame_sync, i_bit_clock};
      sync2_r <= sync1_r;
      bclk_d_r <= sync2_r[0];
      cnt_r <= cnt_nxt;
      in_shift_r <= in_shift_nxt;
      hold_r <= hold_nxt;
      o_data_out <= out_nxt;
      o_data_oe <= oe_nxt;
    end
  end

  a_out_on_rise: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $changed(o_data_out) |-> $past(bclk_rise))
    else $error("data out moved without a bit clock rise");
  a_in_on_fall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $changed(in_shift_r) |-> $past(bclk_fall))
    else $error("input sampled without a bit clock fall");
  a_oe_needs_en: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_data_oe |-> $past(cfg.enable))
    else $error("output driven while the side is disabled");
endmodule
`default_nettype wire

// ===== adpcm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host of the three wire port; its clock rests low between writes.
module adpcm_host_model (
  input wire logic i_slow,
  output var logic o_sclk,
  output var logic o_sdi,
  output var logic o_cs_n
);
  initial begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_cs_n = 1'b1;
  end
  // Sends whole bytes LSB first; drop cuts bits off the tail.
  task automatic send(input logic [7:0] q[$], input int drop);
    int h;
    // Both half periods are whole core clock periods; the slow one
    // keeps the port clock just below its standby limit.
    h = i_slow ? 12830 : 80;
    o_cs_n = 1'b0;
    #h;
    for (int i = 0; i < q.size() * 8 - drop; i++) begin
      o_sdi = q[i / 8][i % 8];
      #h o_sclk = 1'b1;
      #h o_sclk = 1'b0;
    end
    #h o_cs_n = 1'b1;
    // A released data line must not keep its last level.
    o_sdi = ~o_sdi;
  endtask
endmodule
`default_nettype wire

// ===== adpcm_channel_config_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module adpcm_channel_config_port_tb_top;
  import adpcm_cfg_pkg::*;
  logic clk = 0, rst_n = 0, strap = 1, slow = 0, on = 0;
  logic bclk = 0, fs = 0, side_x_data_in = 0, side_y_data_in = 0;
  logic [5:0] addr = 6'h2a;
  logic sclk, config_serial_in, cs_n, xo, xoe, yo, yoe, stby, busy, xmu, ymu;
  logic [7:0] xc, yc;
  chan_mode_type xm, ym;
  rate_type xr, yr;
  int errors = 0, cmp_count = 0, fcnt = 0, nx, ny;
  integer seed = 32'h65f0_a058;
  // Expected control bytes, index 1 is channel X.
  logic [7:0] mc[2];
  logic [7:0] tab[8] = '{8'h00, 8'hc3, 8'h82, 8'h80,
                         8'h09, 8'h01, 8'h28, 8'h41};
  always #5 clk = ~clk;
  always #80 bclk = ~bclk;
  // Backplane: one frame is 64 bits, data moves after each rise.
  always @(posedge bclk) begin
    fs <= #1 (fcnt == 0);
    {side_x_data_in, side_y_data_in} <= #1 2'($random(seed));
    fcnt <= (fcnt + 1) % 64;
  end
  adpcm_channel_config_port u_dut (
    .i_clk(clk), .i_arst_n(rst_n), .i_port_select_strap(strap),
    .i_device_addr_pins(addr), .i_serial_clock(sclk),
    .i_config_serial_in(config_serial_in), .i_chip_select_n(cs_n),
    .i_side_x_bit_clock(bclk), .i_side_x_frame_sync(fs),
    .i_side_x_data_in(side_x_data_in), .i_side_y_bit_clock(bclk),
    .i_side_y_frame_sync(fs), .i_side_y_data_in(side_y_data_in),
    .o_side_x_data_out(xo), .o_side_x_data_out_oe(xoe),
    .o_side_y_data_out(yo), .o_side_y_data_out_oe(yoe),
    .o_x_control(xc), .o_y_control(yc), .o_x_mode(xm), .o_y_mode(ym),
    .o_x_rate(xr), .o_y_rate(yr), .o_x_mu_law(xmu), .o_y_mu_law(ymu),
    .o_standby(stby), .o_update_busy(busy));
  adpcm_host_model u_host (.i_slow(slow), .o_sclk(sclk), .o_sdi(config_serial_in),
    .o_cs_n(cs_n));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // Data may only move while the bit clock is high, after its rise.
  always @(xo, yo) if (on) chk("out_edge", 8'(bclk), 8'h01);
  function automatic logic [7:0] emode(logic [7:0] c);
    if (c[5]) return 8'h00;
    if (c[3]) return 8'h01;
    return c[0] ? 8'h02 : 8'h03;
  endfunction
  function automatic logic [7:0] erate(logic [7:0] c);
    case ({c[1], c[6], c[7]})
      3'h0: return 8'h00;
      3'h7: return 8'h01;
      3'h5: return 8'h02;
      default: return 8'h03;
    endcase
  endfunction
  // Compares every decoded output of both channels with the model.
  task automatic chkall();
    // Sample away from the edge that updates the registers.
    @(negedge clk);
    for (int c = 0; c < 2; c++) begin
      chk("ctl", c ? xc : yc, mc[c]);
      chk("mode", 8'(c ? xm : ym), emode(mc[c]));
      chk("rate", 8'(c ? xr : yr), erate(mc[c]));
      chk("law", 8'(c ? xmu : ymu), 8'(mc[c][2]));
    end
    chk("standby", 8'(stby), 8'(mc[0][5] & mc[1][5]));
  endtask
  task automatic wr(logic s, logic [5:0] a, logic [7:0] c, int n,
                    int drop);
    logic [7:0] q[$];
    // Start just after a core clock rise, like the reset and strap changes.
    @(posedge clk);
    #1;
    q = '{{1'b0, s, a}, c, 8'h00, 8'h01};
    q = q[0:n - 1];
    u_host.send(q, drop);
    repeat (8) @(posedge clk);
    if (strap && a == addr && drop == 0) mc[s] = c;
  endtask
  // Counts output enable cycles over two frames.
  task automatic watch();
    // Start at a frame boundary so the window holds two whole frames.
    @(posedge fs);
    nx = 0;
    ny = 0;
    on = 1;
    repeat (2048) @(negedge clk) begin
      nx += int'(xoe === 1'b1);
      ny += int'(yoe === 1'b1);
    end
    on = 0;
  endtask
  // Pulses the reset pin; both channels return to idle.
  task automatic pulse();
    @(posedge clk) #1 rst_n = 0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    mc = '{8'h20, 8'h20};
    repeat (4) @(posedge clk);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    errors++;
    results();
  end
  initial begin
    logic [7:0] c;
    logic b;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    mc = '{8'h20, 8'h20};
    repeat (4) @(posedge clk);
    chkall();
    chk("oe", {6'h0, xoe, yoe}, 8'h00);
    // Standby allows only a slow port clock.
    slow = 1;
    // Y passes 4 bit slots through, X later 8 bit ones.
    wr(0, addr, 8'h08, 2, 0);
    slow = 0;
    chkall();
    for (int i = 0; i < 8; i++) begin
      c = tab[i] | 8'($random(seed) & 4);
      fork
        wr(1, addr, c, (i == 2) ? 4 : 2, 0);
        begin
          for (int k = 0; k < 400 && busy !== 1'b1; k++) @(negedge clk);
          @(negedge clk);
          chk("busy", 8'(busy), 8'h01);
          chk("oe_busy", {6'h0, xoe, yoe}, 8'h00);
        end
      join
      chkall();
    end
    wr(1, addr ^ 6'h01, 8'h01, 2, 0);
    wr(1, addr ^ 6'h20, 8'h01, 2, 0);
    chkall();
    // A write cut in its second byte must leave the register alone.
    wr(1, addr, 8'h01, 2, 4);
    chkall();
    wr(1, addr, 8'h11, 2, 0);
    chkall();
    repeat (200) @(posedge clk);
    mc[1] = 8'h01;
    chkall();
    // X drives slot 1 of 8 bits, Y slot 0 of 4 bits: 128 and 64
    // core cycles in each 1024 cycle frame.
    wr(1, addr, 8'h09, 4, 0);
    watch();
    chk("x_oe_on", 8'(nx / 4), 8'h40);
    chk("y_oe_on", 8'(ny / 4), 8'h20);
    wr(1, addr, 8'h29, 2, 0);
    chkall();
    watch();
    chk("x_oe_idle", 8'(nx != 0), 8'h00);
    chk("y_oe_kept", 8'(ny / 4), 8'h20);
    // Entering hardware mode takes a reset pulse; the port then ignores
    // even a matching command byte, sent slowly since both sides idle.
    @(posedge clk) #1 strap = 0;
    pulse();
    chkall();
    slow = 1;
    fork
      wr(1, addr, 8'h01, 2, 8);
      begin
        b = 1'b0;
        @(negedge cs_n);
        while (cs_n === 1'b0) begin
          @(negedge clk);
          b |= busy;
        end
        chk("hw_busy", 8'(b), 8'h00);
      end
    join
    @(posedge clk) #1 strap = 1;
    pulse();
    chkall();
    results();
  end
endmodule
`default_nettype wire
